// ---- include/result_if.sv ----
interface result_if;
  logic we;
  logic [2:0] widx;
  logic [11:0] wdata;
  logic [7:0] raddr;
  logic rd_take;
  logic [7:0] rdata;

  modport writer(output we, output widx, output wdata, output raddr, output rd_take,
                 input rdata);
  modport store(input we, input widx, input wdata, input raddr, input rd_take,
                output rdata);
endinterface

// ---- include/shield_adc_pkg.sv ----
package shield_adc_pkg;

  localparam int CLK_PERIOD_NS = 8;

  localparam logic [6:0] SLAVE_ADDR = 7'h5E;
  localparam int NUM_INPUTS = 6;
  localparam int RESULT_W = 12;
  localparam int BYTE_W = 8;
  localparam int NUM_CONV_PINS = 9;
  localparam int CONV_CH_W = $clog2(NUM_CONV_PINS);

  // Entry i belongs to shield analog input i.
  localparam logic [NUM_INPUTS-1:0][7:0] LOW_OFFSET =
    {8'h2E, 8'h34, 8'h36, 8'h28, 8'h26, 8'h30};
  localparam logic [NUM_INPUTS-1:0][7:0] HIGH_OFFSET =
    {8'h2F, 8'h35, 8'h37, 8'h29, 8'h27, 8'h31};
  localparam logic [NUM_INPUTS-1:0][CONV_CH_W-1:0] CONV_CHANNEL =
    {4'h4, 4'h7, 4'h8, 4'h1, 4'h0, 4'h5};

  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // Shortest pulse on SCL or SDA that is taken as a real level change.
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest wait for a conversion before the channel is skipped.
  localparam int CONV_TIMEOUT_NS = 10000;
  localparam int CONV_TIMEOUT_CYC = CONV_TIMEOUT_NS / CLK_PERIOD_NS;
  // Gap between the end of one conversion (done or timeout) and the start of the next.
  localparam int SAMPLE_PERIOD_NS = 100000;
  localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic hit;
    logic hi;
    logic [2:0] idx;
  } reg_sel_s;

  function automatic reg_sel_s reg_decode(input logic [7:0] addr);
    reg_sel_s sel;
    sel = '0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (addr == LOW_OFFSET[i]) begin
        sel.hit = 1'b1;
        sel.hi = 1'b0;
        sel.idx = 3'(i);
      end
      if (addr == HIGH_OFFSET[i]) begin
        sel.hit = 1'b1;
        sel.hi = 1'b1;
        sel.idx = 3'(i);
      end
    end
    return sel;
  endfunction

endpackage

// ---- rtl/result_store.sv ----
module result_store
  import shield_adc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  result_if.store bus
);

  typedef struct packed {
    logic [NUM_INPUTS-1:0][RESULT_W-1:0] mem;
    logic [7:0] rdata;
    logic shadow_vld;
    logic [2:0] shadow_idx;
    logic [3:0] shadow_nib;
  } store_s;

  store_s s_ff;
  store_s nxt_s;
  reg_sel_s sel;

  assign bus.rdata = s_ff.rdata;

  always_comb begin
    nxt_s = s_ff;
    sel = reg_decode(bus.raddr);
    if (bus.we) begin
      nxt_s.mem[bus.widx] = bus.wdata;
    end
    // Bits above the 12-bit result read as zero in the high byte.
    if (!sel.hit) begin
      nxt_s.rdata = UNMAPPED_DATA;
    end else if (!sel.hi) begin
      nxt_s.rdata = s_ff.mem[sel.idx][7:0];
    end else if (s_ff.shadow_vld && s_ff.shadow_idx == sel.idx) begin
      nxt_s.rdata = {4'h0, s_ff.shadow_nib};
    end else begin
      nxt_s.rdata = {4'h0, s_ff.mem[sel.idx][11:8]};
    end
    // Taking a low byte freezes its upper nibble, so a low-then-high read pair belongs to one
    // conversion when a new one lands between, unless it lands in the two cycles before the take.
    if (bus.rd_take && sel.hit) begin
      if (!sel.hi) begin
        nxt_s.shadow_vld = 1'b1;
        nxt_s.shadow_idx = sel.idx;
        nxt_s.shadow_nib = s_ff.mem[sel.idx][11:8];
      end else begin
        nxt_s.shadow_vld = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_ff.mem <= {NUM_INPUTS{RESULT_RESET}};
      s_ff.rdata <= UNMAPPED_DATA;
      s_ff.shadow_vld <= 1'b0;
      s_ff.shadow_idx <= 3'h0;
      s_ff.shadow_nib <= 4'h0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

// ---- rtl/shield_adc_i2c_readout.sv ----
//Contract
// - Answer as an I2C slave at 7-bit address 0x5E and ignore every other address.
// - Work with the master running SCL at 100 kHz or at 400 kHz.
// - Split each 12-bit result over two adjacent 8-bit registers.
// - Result registers are read-only; a master write never changes a result.
// - Input 0 has bits 7:0 at 0x30 and bits 11:8 in the low nibble of 0x31.
// - Input 1 has its low byte at 0x26 and its upper bits at 0x27.
// - Input 2 has its low byte at 0x28 and its upper bits at 0x29.
// - Input 3 has its low byte at 0x36 and its upper bits at 0x37.
// - Input 4 has its low byte at 0x34 and its upper bits at 0x35.
// - Input 5 has its low byte at 0x2E and its upper bits at 0x2F.
// - Inputs 0, 1 and 2 are sampled on converter channels 5, 0 and 1.
// - Inputs 3, 4 and 5 are sampled on converter channels 8, 7 and 4.
// - The converter has nine pins, six for the shield and three for current sensing.
module shield_adc_i2c_readout
  import shield_adc_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_PERIOD_CYC
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic conv_start_out,
  output logic [shield_adc_pkg::CONV_CH_W-1:0] conv_channel_out,
  input wire logic conv_done_in,
  input wire logic [shield_adc_pkg::RESULT_W-1:0] conv_data_in
);

  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [3:0] {
    I2C_IDLE = 4'h0,
    I2C_ADDR = 4'h1,
    I2C_ADDR_ACK = 4'h2,
    I2C_PTR = 4'h3,
    I2C_PTR_ACK = 4'h4,
    I2C_WDATA = 4'h5,
    I2C_WDATA_ACK = 4'h6,
    I2C_RDATA = 4'h7,
    I2C_RACK = 4'h8
  } i2c_e;

  typedef enum logic [1:0] {
    CONV_GAP = 2'h0,
    CONV_REQ = 2'h1,
    CONV_WAIT = 2'h2
  } conv_e;

  localparam int GAP_W = $clog2(SAMPLE_PERIOD + 1);
  localparam int TMO_W = $clog2(CONV_TIMEOUT_CYC + 1);
  localparam int SPK_W = $clog2(SPIKE_CYC + 1);

  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] filt;
    logic [1:0][SPK_W-1:0] fcnt;
    logic scl_d;
    logic sda_d;
    i2c_e st;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic rnw;
    logic nack;
    logic [7:0] ptr;
    logic drive_low;
    logic rd_take;
    conv_e cst;
    logic [2:0] in_idx;
    logic [GAP_W-1:0] gap_cnt;
    logic [TMO_W-1:0] tmo_cnt;
    logic conv_start;
    logic [CONV_CH_W-1:0] conv_ch;
    logic we;
    logic [2:0] widx;
    logic [RESULT_W-1:0] wdata;
  } state_s;

  state_s s_ff;
  state_s nxt_s;
  result_if res();

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  ////////////////////////////////////////////////////////////////////////////

  result_store u_store (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .bus(res.store)
  );

  assign res.we = s_ff.we;
  assign res.widx = s_ff.widx;
  assign res.wdata = s_ff.wdata;
  assign res.raddr = s_ff.ptr;
  assign res.rd_take = s_ff.rd_take;

  // The line is open drain: the pin is only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe_out = s_ff.drive_low;
  assign conv_start_out = s_ff.conv_start;
  assign conv_channel_out = s_ff.conv_ch;

  // Edges are found on the filtered levels; sync_a/sync_b bit 0 feeds bit 1 only.
  assign scl = s_ff.filt[0];
  assign sda = s_ff.filt[1];
  assign scl_rise = scl && !s_ff.scl_d;
  assign scl_fall = !scl && s_ff.scl_d;
  assign start_seen = scl && s_ff.scl_d && s_ff.sda_d && !sda;
  assign stop_seen = scl && s_ff.scl_d && !s_ff.sda_d && sda;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [1:0] synced;
    synced = 2'b00;
    nxt_s = s_ff;
    nxt_s.rd_take = 1'b0;
    nxt_s.we = 1'b0;
    nxt_s.conv_start = 1'b0;

    // Two flip-flops per pin, then a spike filter. At 125 MHz a 400 kHz
    // SCL half period is over 150 cycles, so the 7-cycle filter and the
    // sync delay cost nothing at either rate.
    nxt_s.sync_a = {s_ff.sync_a[0], scl_in};
    nxt_s.sync_b = {s_ff.sync_b[0], sda_in};
    synced = {s_ff.sync_b[1], s_ff.sync_a[1]};
    for (int i = 0; i < 2; i++) begin
      if (synced[i] == s_ff.filt[i]) begin
        nxt_s.fcnt[i] = '0;
      end else if (s_ff.fcnt[i] == SPK_W'(SPIKE_CYC - 1)) begin
        nxt_s.fcnt[i] = '0;
        nxt_s.filt[i] = synced[i];
      end else begin
        nxt_s.fcnt[i] = s_ff.fcnt[i] + SPK_W'(1);
      end
    end
    nxt_s.scl_d = scl;
    nxt_s.sda_d = sda;

    //////////////////////////////////////////////////////////////////////////

    if (start_seen) begin
      // A repeated start keeps the pointer for the read that follows.
      nxt_s.st = I2C_ADDR;
      nxt_s.bitcnt = 4'h0;
      nxt_s.drive_low = 1'b0;
    end else if (stop_seen) begin
      nxt_s.st = I2C_IDLE;
      nxt_s.drive_low = 1'b0;
    end else begin
      unique case (s_ff.st)
        I2C_IDLE: begin
          nxt_s.drive_low = 1'b0;
        end
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          if (scl_rise && s_ff.bitcnt < 4'h8) begin
            nxt_s.shreg = {s_ff.shreg[6:0], sda};
            nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
          end
          if (scl_fall && s_ff.bitcnt == 4'h8) begin
            nxt_s.bitcnt = 4'h0;
            if (s_ff.st == I2C_ADDR) begin
              if (s_ff.shreg[7:1] == SLAVE_ADDR) begin
                nxt_s.drive_low = 1'b1;
                nxt_s.rnw = s_ff.shreg[0];
                nxt_s.st = I2C_ADDR_ACK;
              end else begin
                nxt_s.st = I2C_IDLE;
              end
            end else if (s_ff.st == I2C_PTR) begin
              nxt_s.ptr = s_ff.shreg;
              nxt_s.drive_low = 1'b1;
              nxt_s.st = I2C_PTR_ACK;
            end else begin
              // Written data is acked to keep the bus moving, then dropped.
              nxt_s.drive_low = 1'b1;
              nxt_s.st = I2C_WDATA_ACK;
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (scl_fall) begin
            if (s_ff.rnw) begin
              nxt_s.shreg = res.rdata;
              nxt_s.rd_take = 1'b1;
              nxt_s.drive_low = !res.rdata[7];
              nxt_s.st = I2C_RDATA;
            end else begin
              nxt_s.drive_low = 1'b0;
              nxt_s.st = I2C_PTR;
            end
          end
        end
        I2C_PTR_ACK, I2C_WDATA_ACK: begin
          if (scl_fall) begin
            nxt_s.drive_low = 1'b0;
            nxt_s.st = I2C_WDATA;
          end
        end
        I2C_RDATA: begin
          if (scl_fall) begin
            if (s_ff.bitcnt == 4'h7) begin
              nxt_s.bitcnt = 4'h0;
              nxt_s.drive_low = 1'b0;
              nxt_s.ptr = s_ff.ptr + 8'h01;
              nxt_s.st = I2C_RACK;
            end else begin
              nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
              nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
              nxt_s.drive_low = !s_ff.shreg[6];
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            nxt_s.nack = sda;
          end
          if (scl_fall) begin
            if (!s_ff.nack) begin
              // The pointer moved a full SCL period ago, so the store's
              // registered read data already shows the next byte.
              nxt_s.shreg = res.rdata;
              nxt_s.rd_take = 1'b1;
              nxt_s.drive_low = !res.rdata[7];
              nxt_s.st = I2C_RDATA;
            end else begin
              nxt_s.st = I2C_IDLE;
            end
          end
        end
        default: begin
          nxt_s.st = I2C_IDLE;
          nxt_s.drive_low = 1'b0;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////

    // Only the six shield channels are scanned; the three current-sense
    // pins of the converter are left to other logic.
    unique case (s_ff.cst)
      CONV_GAP: begin
        if (s_ff.gap_cnt == '0) begin
          nxt_s.cst = CONV_REQ;
        end else begin
          nxt_s.gap_cnt = s_ff.gap_cnt - GAP_W'(1);
        end
      end
      CONV_REQ: begin
        nxt_s.conv_start = 1'b1;
        nxt_s.conv_ch = CONV_CHANNEL[s_ff.in_idx];
        nxt_s.tmo_cnt = TMO_W'(CONV_TIMEOUT_CYC - 1);
        nxt_s.cst = CONV_WAIT;
      end
      CONV_WAIT: begin
        if (conv_done_in || s_ff.tmo_cnt == '0) begin
          // A timed-out channel keeps its last good result.
          nxt_s.we = conv_done_in;
          nxt_s.widx = s_ff.in_idx;
          nxt_s.wdata = conv_data_in;
          nxt_s.in_idx = (s_ff.in_idx == 3'(NUM_INPUTS - 1)) ? 3'h0 : s_ff.in_idx + 3'h1;
          nxt_s.gap_cnt = GAP_W'(SAMPLE_PERIOD - 1);
          nxt_s.cst = CONV_GAP;
        end else begin
          nxt_s.tmo_cnt = s_ff.tmo_cnt - TMO_W'(1);
        end
      end
      default: begin
        nxt_s.cst = CONV_GAP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_ff <= '0;
      s_ff.sync_a <= 2'b11;
      s_ff.sync_b <= 2'b11;
      s_ff.filt <= 2'b11;
      s_ff.scl_d <= 1'b1;
      s_ff.sda_d <= 1'b1;
      s_ff.st <= I2C_IDLE;
      s_ff.ptr <= PTR_RESET;
      s_ff.cst <= CONV_REQ;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

// ---- tb/i2c_master_model.sv ----
module i2c_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int lo = 12;
  int hi = 8;
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end
  ////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Data is sampled at the end of the high phase, as the slave only moves it while low.
  task automatic bitx(input logic b, output logic r);
    w(4);
    sda_out = b;
    w(lo - 4);
    scl_out = 1'h1;
    w(hi - 1);
    r = sda_in;
    w(1);
    scl_out = 1'h0;
  endtask
  task automatic start();
    if (!scl_out) begin
      w(4);
      sda_out = 1'h1;
      w(2 * lo);
      scl_out = 1'h1;
      w(hi);
    end
    sda_out = 1'h0;
    w(hi);
    scl_out = 1'h0;
  endtask
  task automatic stop();
    w(4);
    sda_out = 1'h0;
    w(lo);
    scl_out = 1'h1;
    w(hi);
    sda_out = 1'h1;
    w(lo);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'h1, r);
    ack = !r;
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'h1, r);
      d[i] = r;
    end
    bitx(nack, r);
  endtask
  // Low byte then high nibble, scaled by a 3.3 V reference over 4096 codes and a divider of 2.
  function automatic int to_mv(input logic [7:0] lsb_byte, input logic [7:0] msb_byte);
    return ((int'(msb_byte[3:0]) * 256 + int'(lsb_byte)) * 6600) / 4096;
  endfunction
endmodule

// ---- tb/shield_adc_i2c_readout_monitor.sv ----
module adc_readout_checker
  import shield_adc_pkg::*;
#(
  parameter int SAMPLE_PERIOD = 20
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic conv_start_out,
  input wire logic [shield_adc_pkg::CONV_CH_W-1:0] conv_channel_out,
  input wire logic conv_done_in,
  input wire logic [shield_adc_pkg::RESULT_W-1:0] conv_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0][3:0] CH_SEQ = {4'h4, 4'h7, 4'h8, 4'h1, 4'h0, 4'h5};
  logic [2:0] k_ff;
  logic wait_ff;
  logic armed_ff;
  int idle_ff;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  // The gap counter only restarts on an answered request, so a skipped channel is not modelled.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      k_ff <= 3'h0;
      wait_ff <= 1'h0;
      armed_ff <= 1'h0;
      idle_ff <= 0;
    end else begin
      if (conv_start_out) begin
        k_ff <= (k_ff == 3'h5) ? 3'h0 : k_ff + 3'h1;
        wait_ff <= 1'h1;
      end
      if (conv_done_in && wait_ff) begin
        wait_ff <= 1'h0;
        armed_ff <= 1'h1;
        idle_ff <= 0;
      end else begin
        idle_ff <= idle_ff + 1;
      end
    end
  end
  ////////////////////////////////////////
  chan_seq_a:
    assert property (conv_start_out |-> conv_channel_out == CH_SEQ[k_ff])
    else $error("converter channel out of sequence");
  start_pulse_a:
    assert property (conv_start_out |=> !conv_start_out)
    else $error("start request longer than one cycle");
  chan_hold_a:
    assert property (!conv_start_out |-> $stable(conv_channel_out))
    else $error("channel moved without a request");
  gap_min_a:
    assert property (conv_start_out && armed_ff |-> idle_ff >= SAMPLE_PERIOD)
    else $error("conversion started too early");
  gap_max_a:
    assert property (!wait_ff && armed_ff |-> idle_ff <= SAMPLE_PERIOD + 4)
    else $error("conversion started too late");
  release_low_a:
    assert property ($fell(sda_oe_out) |-> !scl_in)
    else $error("data released while clock high");
  drive_low_a:
    assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("data pulled while clock high");
  reset_idle_a:
    assert property ($fell(rst_in) |-> !sda_oe_out && !conv_start_out && conv_channel_out == 4'h0)
    else $error("outputs busy after reset");
endmodule

bind shield_adc_i2c_readout adc_readout_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) chk (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .conv_start_out(conv_start_out),
  .conv_channel_out(conv_channel_out),
  .conv_done_in(conv_done_in),
  .conv_data_in(conv_data_in)
);

// ---- tb/tb_shield_adc_i2c_readout.sv ----
module tb_shield_adc_i2c_readout;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SP = 20;
  localparam logic [5:0][7:0] LO = {8'h2E, 8'h34, 8'h36, 8'h28, 8'h26, 8'h30};
  localparam logic [5:0][3:0] CH = {4'h4, 4'h7, 4'h8, 4'h1, 4'h0, 4'h5};
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic conv_done_in = 1'h0;
  logic [11:0] conv_data_in = 12'h000;
  logic scl;
  logic m_sda;
  logic sda_out;
  logic sda_oe_out;
  logic conv_start_out;
  logic [3:0] conv_channel_out;
  logic [11:0] v;
  logic [7:0] rb0;
  logic [7:0] rb1;
  logic mute = 1'h0;
  int mv;
  int dly = 0;
  int miscompares = 0;
  int checks = 0;
  wire sda = m_sda & ~(sda_oe_out & ~sda_out);

  shield_adc_i2c_readout #(.SAMPLE_PERIOD(SP)) uut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .conv_start_out(conv_start_out),
    .conv_channel_out(conv_channel_out),
    .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in)
  );
  i2c_master_model mst (.clk_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));

  initial forever #4 clock_in = ~clock_in;
  ////////////////////////////////////////
  function automatic logic [11:0] val(input logic [3:0] c);
    return {c ^ 4'hC, c ^ 4'h6, c};
  endfunction
  // Answer time grows with the channel so both quick and slow conversions occur.
  // A muted converter never answers, so the block has to time out and keep old results.
  always @(negedge clock_in) begin
    if (rst_in) dly <= 0;
    else if (conv_start_out) dly <= 32'(conv_channel_out) + 2;
    else if (dly > 0) dly <= dly - 1;
    conv_done_in <= (dly == 1) && !mute;
    if (dly == 1) conv_data_in <= val(conv_channel_out);
    else conv_data_in <= ~conv_data_in;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd2(input logic [6:0] dev, input logic [7:0] ptr, e0, e1);
    logic a;
    logic [7:0] d;
    mst.start();
    mst.wr({dev, 1'h0}, a);
    chk({7'h00, a}, {7'h00, dev == 7'h5E});
    if (a) begin
      mst.wr(ptr, a);
      chk({7'h00, a}, 8'h01);
      mst.start();
      mst.wr({dev, 1'h1}, a);
      chk({7'h00, a}, 8'h01);
      mst.rd(1'h0, d);
      chk(d, e0);
      rb0 = d;
      mst.rd(1'h1, d);
      chk(d, e1);
      rb1 = d;
    end
    mst.stop();
  endtask
  task automatic rd_in(input int i);
    v = val(CH[i]);
    rd2(7'h5E, LO[i], v[7:0], {4'h0, v[11:8]});
    mv = (int'(v) * 6600) / 4096;
    chk(8'(mst.to_mv(rb0, rb1) >> 8), 8'(mv >> 8));
    chk(8'(mst.to_mv(rb0, rb1)), 8'(mv));
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clock_in);
    miscompares++;
    complete_run();
  end
  initial begin
    logic a;
    repeat (10) @(negedge clock_in);
    rst_in = 1'h0;
    repeat (400) @(negedge clock_in);
    for (int i = 0; i < 6; i++) rd_in(i);
    rd2(7'h2F, 8'h30, 8'h00, 8'h00);
    rd2(7'h5F, 8'h30, 8'h00, 8'h00);
    rd2(7'h5E, 8'h32, 8'h00, 8'h00);
    // With no fresh conversions landing, a result changed by the write would stay visible.
    mute = 1'h1;
    mst.start();
    mst.wr(8'hBC, a);
    mst.wr(8'h30, a);
    mst.wr(8'hFF, a);
    mst.wr(8'hFF, a);
    chk({7'h00, a}, 8'h01);
    mst.stop();
    rd_in(0);
    mute = 1'h0;
    mst.lo = 156;
    mst.hi = 156;
    rd_in(5);
    mst.lo = 12;
    mst.hi = 8;
    rst_in = 1'h1;
    repeat (3) @(negedge clock_in);
    rst_in = 1'h0;
    repeat (400) @(negedge clock_in);
    rd_in(3);
    complete_run();
  end
endmodule
